/* logic/clk_ctrl_pkg.sv */
// constants, encodings and carrier types for the clock output and crystal control block
// assumes an axi4-lite master with 32-bit data and one word per register
package clk_ctrl_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [15:0] IDX_CLOCK_OUTPUT_PIN_CTRL = 16'h4090;
  localparam logic [15:0] IDX_XTAL_CTRL   = 16'h4091;
  localparam logic [15:0] IDX_STATUS      = 16'h40c0;
  localparam logic [31:0] ADDR_CLOCK_OUTPUT_PIN_CTRL = {14'h0000, IDX_CLOCK_OUTPUT_PIN_CTRL, 2'b00};
  localparam logic [31:0] ADDR_XTAL_CTRL   = {14'h0000, IDX_XTAL_CTRL, 2'b00};
  localparam logic [31:0] ADDR_STATUS      = {14'h0000, IDX_STATUS, 2'b00};

  // clock_output_control fields
  localparam int unsigned CLK_ENA_BIT  = 15;
  localparam int unsigned DRIVE_BIT    = 13;
  localparam int unsigned ON_SLOT_LSB  = 8;
  localparam int unsigned SLP_SLOT_LSB = 4;

  // crystal_oscillator_control fields
  localparam int unsigned INHIBIT_BIT   = 15;
  localparam int unsigned CRYSTAL_OSC_ENABLE_BIT  = 13;
  localparam int unsigned KEEPALIVE_BIT = 12;

  // status fields (read only)
  localparam int unsigned ST_ACTIVE_BIT = 0;
  localparam int unsigned ST_SRC_BIT    = 1;
  localparam int unsigned ST_KEY_BIT    = 2;
  localparam int unsigned ST_XVALID_BIT = 3;

  // reset values
  localparam logic [15:0] CLOCK_OUTPUT_PIN_CTRL_RST = 16'h0000;
  localparam logic [15:0] XTAL_CTRL_RST   = 16'h1000;

  // timeslot codes
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST  = 3'h5;
  localparam logic [2:0] SLOT_MIRROR = 3'h6;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_SLEEP, PWR_BACKUP} pwr_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  // configuration image pushed by the non-volatile loader
  typedef struct packed {
    logic        valid;
    logic [15:0] clock_output_pin_ctrl;
    logic [15:0] xtal_ctrl;
  } cfg_load_t;

  // one pulse per timeslot of the power-up or sleep sequence
  typedef struct packed {
    logic       strobe;
    logic       sleeping;
    logic [2:0] slot;
  } slot_evt_t;

  // sampled oscillator levels and crystal health
  typedef struct packed {
    logic rc_level;
    logic xtal_level;
    logic xtal_valid;
  } osc_in_t;

endpackage : clk_ctrl_pkg

/* logic/clock_output_crystal_control.sv */
// clock output pin control and crystal oscillator control with an axi4-lite register slave
// assumes all inputs synchronous to aclk; oscillator levels arrive already sampled
// assumes the sequencer strobes one slot event per timeslot, power-up or sleep
// assumes the configuration loader is the only path that may set the crystal enable
`timescale 1ns/100ps

module clock_output_crystal_control (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire clk_ctrl_pkg::axil_req_t axil_req,
  output      clk_ctrl_pkg::axil_rsp_t axil_rsp,
  input  wire logic                    key_unlocked,
  input  wire clk_ctrl_pkg::cfg_load_t cfg_load,
  input  wire clk_ctrl_pkg::slot_evt_t slot_evt,
  input  wire clk_ctrl_pkg::pwr_state_t pwr_state,
  input  wire clk_ctrl_pkg::osc_in_t   osc_in,
  input  wire logic                    on_request,
  output      logic                    on_grant,
  output      logic                    xtal_osc_run,
  output      logic                    rtc_clock_en,
  output      logic                    clock_src_xtal,
  output      logic                    clock_output_pin_o,
  output      logic                    clock_output_pin_oe
);
  import clk_ctrl_pkg::*;

  typedef struct packed {
    logic        clock_out_enable_bit;
    logic        clock_out_drive_type;
    logic [2:0]  clock_out_on_slot;
    logic [2:0]  clock_out_sleep_slot;
    logic        crystal_startup_inhibit;
    logic        crystal_osc_enable;
    logic        rtc_backup_keepalive;
    logic        out_active;
    logic        src_xtal;
    logic        pin_o;
    logic        pin_oe;
    logic        aw_have;
    logic [31:0] aw_addr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  // registered state and the next value that one always_comb builds
  state_t q;
  state_t d;

  // bus decode, register images and sequencer helpers
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [15:0] clock_output_pin_word;
  logic [15:0] xtal_word;
  logic [15:0] status_word;
  logic [15:0] merged;
  logic        on_hit;
  logic        sleep_hit;
  logic        sleep_coded;
  logic        want_xtal;
  logic        level;

  // merge the two low byte lanes; upper lanes carry nothing and are dropped
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : merge_lanes

  // register images as software sees them; reserved bits read as zero
  always_comb begin
    clock_output_pin_word = 16'h0000;
    clock_output_pin_word[CLK_ENA_BIT] = q.clock_out_enable_bit;
    clock_output_pin_word[DRIVE_BIT] = q.clock_out_drive_type;
    clock_output_pin_word[ON_SLOT_LSB +: 3] = q.clock_out_on_slot;
    clock_output_pin_word[SLP_SLOT_LSB +: 3] = q.clock_out_sleep_slot;
    xtal_word = 16'h0000;
    xtal_word[INHIBIT_BIT] = q.crystal_startup_inhibit;
    xtal_word[CRYSTAL_OSC_ENABLE_BIT] = q.crystal_osc_enable;
    xtal_word[KEEPALIVE_BIT] = q.rtc_backup_keepalive;
    status_word = 16'h0000;
    status_word[ST_ACTIVE_BIT] = q.out_active;
    status_word[ST_SRC_BIT] = q.src_xtal;
    status_word[ST_KEY_BIT] = key_unlocked;
    status_word[ST_XVALID_BIT] = osc_in.xtal_valid;
  end

  // handshakes: address and data are taken independently, one write at a time
  assign aw_take = axil_req.awvalid && !q.aw_have && !q.bvalid;
  assign w_take  = axil_req.wvalid && !q.w_have && !q.bvalid;
  assign ar_take = axil_req.arvalid && !q.rvalid;

  // a write fires once both halves are held or arrive this cycle
  assign do_write = (q.aw_have || aw_take) && (q.w_have || w_take);
  assign wr_addr  = q.aw_have ? q.aw_addr : axil_req.awaddr;
  assign wr_data  = q.w_have ? q.wdata : axil_req.wdata;
  assign wr_strb  = q.w_have ? q.wstrb : axil_req.wstrb;

  // sequencer slot decode
  // sleep codes count down from slot five, so code c acts in slot six minus c
  assign on_hit = slot_evt.strobe && !slot_evt.sleeping &&
                  (q.clock_out_on_slot >= SLOT_FIRST) &&
                  (q.clock_out_on_slot <= SLOT_LAST) &&
                  (slot_evt.slot == q.clock_out_on_slot);
  assign sleep_coded = (q.clock_out_sleep_slot >= SLOT_FIRST) &&
                       (q.clock_out_sleep_slot <= SLOT_LAST);
  assign sleep_hit = slot_evt.strobe && slot_evt.sleeping && sleep_coded &&
                     (slot_evt.slot == 3'(SLOT_MIRROR - q.clock_out_sleep_slot));

  // crystal takes over only once reported valid and its enable bit is set
  assign want_xtal = osc_in.xtal_valid && q.crystal_osc_enable;
  assign level     = q.src_xtal ? osc_in.xtal_level : osc_in.rc_level;

  // next-state logic for registers, sequencing and the bus slave
  always_comb begin
    d = q;
    merged = 16'h0000;

    // each write half is held until its partner arrives, so either order works
    if (aw_take) begin
      d.aw_have = 1'b1;
      d.aw_addr = axil_req.awaddr;
    end
    if (w_take) begin
      d.w_have = 1'b1;
      d.wdata  = axil_req.wdata;
      d.wstrb  = axil_req.wstrb;
    end

    if (do_write) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      unique case (wr_addr)
        ADDR_CLOCK_OUTPUT_PIN_CTRL: begin
          merged = merge_lanes(clock_output_pin_word, wr_data[15:0], wr_strb[1:0]);
          d.clock_out_drive_type = merged[DRIVE_BIT];
          d.clock_out_on_slot = merged[ON_SLOT_LSB +: 3];
          d.clock_out_sleep_slot = merged[SLP_SLOT_LSB +: 3];
          // drive type and slot fields take every write, locked or not;
          // a locked write leaves the enable and the output untouched, and a
          // write that skips the upper byte lane must not undo a slot event
          if (key_unlocked && wr_strb[1]) begin
            d.clock_out_enable_bit = merged[CLK_ENA_BIT];
            d.out_active = merged[CLK_ENA_BIT];
          end
        end
        ADDR_XTAL_CTRL: begin
          merged = merge_lanes(xtal_word, wr_data[15:0], wr_strb[1:0]);
          d.crystal_startup_inhibit = merged[INHIBIT_BIT];
          d.rtc_backup_keepalive = merged[KEEPALIVE_BIT];
          // crystal enable bit is deliberately not written here
        end
        ADDR_STATUS: begin
          d.bresp = RESP_OKAY;                                            // read-only, write dropped
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // the response leaves once the master has taken it
    if (q.bvalid && axil_req.bready) begin
      d.bvalid = 1'b0;
    end

    // read data is captured at address acceptance and held until rready
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      unique case (axil_req.araddr)
        ADDR_CLOCK_OUTPUT_PIN_CTRL: d.rdata = {16'h0000, clock_output_pin_word};
        ADDR_XTAL_CTRL:   d.rdata = {16'h0000, xtal_word};
        ADDR_STATUS:      d.rdata = {16'h0000, status_word};
        // unmapped reads answer with an error and zero data
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && axil_req.rready) begin
      d.rvalid = 1'b0;
    end

    // a configuration load overrides a bus write in the same cycle
    if (cfg_load.valid) begin
      d.clock_out_enable_bit = cfg_load.clock_output_pin_ctrl[CLK_ENA_BIT];
      d.clock_out_drive_type = cfg_load.clock_output_pin_ctrl[DRIVE_BIT];
      d.clock_out_on_slot = cfg_load.clock_output_pin_ctrl[ON_SLOT_LSB +: 3];
      d.clock_out_sleep_slot = cfg_load.clock_output_pin_ctrl[SLP_SLOT_LSB +: 3];
      d.crystal_startup_inhibit = cfg_load.xtal_ctrl[INHIBIT_BIT];
      d.crystal_osc_enable = cfg_load.xtal_ctrl[CRYSTAL_OSC_ENABLE_BIT];
      d.rtc_backup_keepalive = cfg_load.xtal_ctrl[KEEPALIVE_BIT];
      d.out_active = cfg_load.clock_output_pin_ctrl[CLK_ENA_BIT];
    end

    // sequencer slots come last so a slot event is never lost to a write
    if (on_hit) begin
      d.out_active = 1'b1;
    end
    if (sleep_hit) begin
      d.out_active = 1'b0;
    end

    // source switch is registered and follows each change of valid and enable, never mid-slot glitching
    d.src_xtal = want_xtal;

    // pin drive: cmos drives both levels, open drain only pulls low
    // limitation: open drain needs an outside pull-up to show a high level
    if (!q.out_active) begin
      d.pin_o  = 1'b0;
      d.pin_oe = 1'b0;
    end else if (q.clock_out_drive_type) begin
      d.pin_o  = 1'b0;
      d.pin_oe = !level;
    end else begin
      d.pin_o  = level;
      d.pin_oe = 1'b1;
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // clear everything, then lay the register defaults over it
      q <= '0;
      q.clock_out_enable_bit <= CLOCK_OUTPUT_PIN_CTRL_RST[CLK_ENA_BIT];
      q.clock_out_drive_type <= CLOCK_OUTPUT_PIN_CTRL_RST[DRIVE_BIT];
      q.clock_out_on_slot <= CLOCK_OUTPUT_PIN_CTRL_RST[ON_SLOT_LSB +: 3];
      q.clock_out_sleep_slot <= CLOCK_OUTPUT_PIN_CTRL_RST[SLP_SLOT_LSB +: 3];
      q.crystal_startup_inhibit <= XTAL_CTRL_RST[INHIBIT_BIT];
      q.crystal_osc_enable <= XTAL_CTRL_RST[CRYSTAL_OSC_ENABLE_BIT];
      q.rtc_backup_keepalive <= XTAL_CTRL_RST[KEEPALIVE_BIT];
      q.bresp <= RESP_OKAY;
      q.rresp <= RESP_OKAY;
    end else begin
      q <= d;
    end
  end

  // bus answers
  // readies come only from registered state, so a new request is taken the cycle after a response leaves
  assign axil_rsp.awready = !q.aw_have && !q.bvalid;
  assign axil_rsp.wready  = !q.w_have && !q.bvalid;
  assign axil_rsp.bvalid  = q.bvalid;
  assign axil_rsp.bresp   = q.bresp;
  assign axil_rsp.arready = !q.rvalid;
  assign axil_rsp.rvalid  = q.rvalid;
  assign axil_rsp.rdata   = q.rdata;
  assign axil_rsp.rresp   = q.rresp;

  // on transition waits for the crystal only when inhibit is set
  // without inhibit the transition goes ahead and the rc oscillator covers the gap
  assign on_grant = on_request &&
                    (!q.crystal_startup_inhibit || osc_in.xtal_valid);

  // oscillator runs in off/on/sleep when enabled; backup needs keep-alive too
  // this only requests the oscillator; its start-up time is the caller's concern
  assign xtal_osc_run = q.crystal_osc_enable &&
                        ((pwr_state != PWR_BACKUP) || q.rtc_backup_keepalive);

  // rtc clocked outside backup; in backup both bits must be set
  assign rtc_clock_en = (pwr_state != PWR_BACKUP) ||
                        (q.rtc_backup_keepalive && q.crystal_osc_enable);

  // source and pin come straight from flip-flops so the pin cannot glitch
  assign clock_src_xtal      = q.src_xtal;
  assign clock_output_pin_o  = q.pin_o;
  assign clock_output_pin_oe = q.pin_oe;

endmodule : clock_output_crystal_control

/* testbench/clock_output_crystal_control_monitor.sv */
// concurrent checks on the clock control block ports
// assumes one domain: aclk with synchronous active-low aresetn
`timescale 1ns/100ps
module clock_output_crystal_control_monitor (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire clk_ctrl_pkg::axil_req_t axil_req,
  input wire clk_ctrl_pkg::axil_rsp_t axil_rsp,
  input wire logic                    key_unlocked,
  input wire clk_ctrl_pkg::cfg_load_t cfg_load,
  input wire clk_ctrl_pkg::slot_evt_t slot_evt,
  input wire clk_ctrl_pkg::pwr_state_t pwr_state,
  input wire clk_ctrl_pkg::osc_in_t   osc_in,
  input wire logic                    on_request,
  input wire logic                    on_grant,
  input wire logic                    xtal_osc_run,
  input wire logic                    rtc_clock_en,
  input wire logic                    clock_src_xtal,
  input wire logic                    clock_output_pin_o,
  input wire logic                    clock_output_pin_oe
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken at one edge
  sequence wr_both;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  endsequence
  sequence rd_taken;
    axil_req.arvalid && axil_rsp.arready;
  endsequence
  chk_write_resp_lat: assert property (wr_both |=> axil_rsp.bvalid)
    else $error("write response late");
  chk_read_resp_lat: assert property (rd_taken |=> axil_rsp.rvalid)
    else $error("read response late");
  chk_write_busy_block: assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write accepted while response pending");
  chk_read_busy_block: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read accepted while response pending");
  chk_grant_needs_req: assert property (on_grant |-> on_request)
    else $error("grant without request");
  chk_grant_valid_xtal: assert property (on_request && osc_in.xtal_valid |-> on_grant)
    else $error("grant withheld with crystal valid");
  chk_rtc_awake_run: assert property (pwr_state != PWR_BACKUP |-> rtc_clock_en)
    else $error("rtc stopped outside backup");
  chk_rtc_backup_pair: assert property (pwr_state == PWR_BACKUP |-> rtc_clock_en == xtal_osc_run)
    else $error("rtc backup gating wrong");
  chk_src_stays_rc: assert property (!$past(osc_in.xtal_valid) |-> !clock_src_xtal)
    else $error("crystal chosen before valid");
  chk_src_to_xtal: assert property (pwr_state != PWR_BACKUP && osc_in.xtal_valid
      |=> clock_src_xtal == $past(xtal_osc_run))
    else $error("source switch wrong");
  // driven pin carries the chosen oscillator one cycle late, for both drive types
  chk_pin_level_src: assert property (clock_output_pin_oe |->
      clock_output_pin_o == ($past(clock_src_xtal) ? $past(osc_in.xtal_level)
                                                    : $past(osc_in.rc_level)))
    else $error("pin level wrong");
endmodule : clock_output_crystal_control_monitor

/* testbench/clk_receiver_model.sv */
// processor clock input that receives the clock output line
// assumes a pull-up on the line, so a released pin reads high
`timescale 1ns/100ps
module clk_receiver_model (
  input  wire logic aclk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      wire_level,
  output int        edges
);
  logic last_q = 1'b1; // line idles high at the pull-up, so no false edge at start
  // open drain only pulls low; released line floats to the pull-up
  assign wire_level = pin_oe ? pin_o : 1'b1;
  initial edges = 0;
  // count rising edges seen by the processor
  always @(posedge aclk) begin
    last_q <= wire_level;
    if (wire_level && !last_q) edges <= edges + 1;
  end
endmodule : clk_receiver_model

/* testbench/clock_output_crystal_control_tb_top.sv */
// self-checking bench for the clock output and crystal control block
// assumes the package constants and an axi4-lite slave answering as handed over
`timescale 1ns/100ps
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module clock_output_crystal_control_tb_top;
  import clk_ctrl_pkg::*;
  logic       aclk = 0;
  logic       aresetn = 0;
  axil_req_t  req = '0;
  axil_rsp_t  rsp;
  logic       key = 0;
  cfg_load_t  cfg = '0;
  slot_evt_t  se = '0;
  pwr_state_t pst = PWR_ON;
  osc_in_t    osc = '0;
  logic       onreq = 0;
  logic       grant, run, rtc, src, pin_o, pin_oe, lvl;
  int         edges, n0, num_errors = 0, compares = 0;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic [15:0] c1 = 16'h0000, w;
  clock_output_crystal_control u_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .key_unlocked(key), .cfg_load(cfg), .slot_evt(se), .pwr_state(pst),
    .osc_in(osc), .on_request(onreq), .on_grant(grant), .xtal_osc_run(run),
    .rtc_clock_en(rtc), .clock_src_xtal(src), .clock_output_pin_o(pin_o),
    .clock_output_pin_oe(pin_oe));
  clk_receiver_model u_rx (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .wire_level(lvl), .edges(edges));
  always #25 aclk = ~aclk;
  // oscillator levels wander randomly so the pin has something to carry
  always @(posedge aclk) begin
    osc.rc_level <= 1'($urandom);
    osc.xtal_level <= 1'($urandom);
  end
  task tally_and_finish();
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // readies are looked at mid-cycle, where they equal what the next edge samples
  task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
    logic aw_ok, w_ok, b_ok;
    int n;
    @(posedge aclk);
    req.awaddr <= a; req.wdata <= {16'h0000, d}; req.wstrb <= 4'hf;
    req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      aw_ok = req.awvalid && rsp.awready; w_ok = req.wvalid && rsp.wready;
      b_ok = rsp.bvalid; rr = rsp.bresp;
      @(posedge aclk);
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
      if (b_ok) break;
    end
    req.bready <= 1'b0;
    if (n == 40) begin num_errors++; tally_and_finish(); end
  endtask : bus_wr
  task automatic bus_rd(input logic [31:0] a);
    logic ar_ok, r_ok;
    int n;
    @(posedge aclk);
    req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ar_ok = req.arvalid && rsp.arready;
      r_ok = rsp.rvalid; rd = rsp.rdata; rr = rsp.rresp;
      @(posedge aclk);
      if (ar_ok) req.arvalid <= 1'b0;
      if (r_ok) break;
    end
    req.arvalid <= 1'b0; req.rready <= 1'b0;
    if (n == 40) begin num_errors++; tally_and_finish(); end
  endtask : bus_rd
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    @(posedge aclk);
    cfg <= '{valid: 1'b1, clock_output_pin_ctrl: a, xtal_ctrl: b};
    @(posedge aclk);
    cfg.valid <= 1'b0;
  endtask : load
  task automatic slot(input logic sl, input int s);
    @(posedge aclk);
    se <= '{strobe: 1'b1, sleeping: sl, slot: 3'(s)};
    @(posedge aclk);
    se.strobe <= 1'b0;
  endtask : slot
  function automatic logic on_exp(input int c, input int s);
    return c >= 1 && c <= 5 && s >= c;
  endfunction : on_exp
  function automatic logic slp_exp(input int c, input int s);
    return !(c >= 1 && c <= 5 && s >= 6 - c);
  endfunction : slp_exp
  initial begin
    void'($urandom(12));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(ADDR_CLOCK_OUTPUT_PIN_CTRL); `CHK("ctrl1", 16'h0000, rd[15:0] & 16'ha770)
    bus_rd(ADDR_XTAL_CTRL); `CHK("ctrl2", 16'h1000, rd[15:0] & 16'hb000)
    // host cannot set the crystal enable
    bus_wr(ADDR_XTAL_CTRL, 16'hb000);
    `CHK("bresp", RESP_OKAY, rr)
    bus_rd(ADDR_XTAL_CTRL); `CHK("ctrl2", 16'h9000, rd[15:0] & 16'hb000)
    bus_rd(32'h0000_0100); `CHK("resp", 2'b10, rr)
    bus_wr(32'h0000_0100, 16'hffff); `CHK("bresp", RESP_SLVERR, rr)
    // random writes with the key alternately locked and unlocked
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      key <= i[0];
      c1 = i[0] ? (w & 16'ha770) : ((w & 16'h2770) | (c1 & 16'h8000));
      bus_wr(ADDR_CLOCK_OUTPUT_PIN_CTRL, w);
      bus_rd(ADDR_CLOCK_OUTPUT_PIN_CTRL); `CHK("ctrl1", c1, rd[15:0] & 16'ha770)
      bus_rd(ADDR_STATUS); `CHK("active", c1[15], rd[0])
      `CHK("key", i[0], rd[ST_KEY_BIT])
    end
    key <= 1'b1;
    bus_wr(ADDR_CLOCK_OUTPUT_PIN_CTRL, 16'h8000);
    n0 = edges;
    repeat (30) @(posedge aclk);
    `CHK("edges", 1'b1, edges > n0)
    bus_wr(ADDR_CLOCK_OUTPUT_PIN_CTRL, 16'h0000);
    repeat (3) @(posedge aclk);
    `CHK("idle", 1'b1, lvl)
    // every pairing of crystal enable and keep-alive, awake and in backup
    for (int k = 0; k < 4; k++) begin
      load(16'h0000, {2'b00, k[1], k[0], 12'h000});
      pst <= PWR_BACKUP;
      @(negedge aclk); `CHK("rtc", k == 3, rtc)
      `CHK("run", k == 3, run)
      @(posedge aclk); pst <= PWR_ON;
      @(negedge aclk); `CHK("run", k[1], run)
    end
    // inhibit holds the on grant until the crystal is valid
    load(16'h0000, 16'hb000);
    onreq <= 1'b1;
    @(negedge aclk); `CHK("grant", 1'b0, grant)
    `CHK("src", 1'b0, src)
    @(posedge aclk); osc.xtal_valid <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk); `CHK("grant", 1'b1, grant)
    `CHK("src", 1'b1, src)
    @(posedge aclk); osc.xtal_valid <= 1'b0;
    load(16'h0000, 16'h3000);
    @(negedge aclk); `CHK("grant", 1'b1, grant)
    // every on-slot and sleep-slot code across the five timeslots
    for (int c = 0; c < 8; c++) begin
      load({5'b00000, 3'(c), 8'h00}, 16'h3000);
      for (int s = 1; s < 6; s++) begin
        slot(1'b0, s);
        bus_rd(ADDR_STATUS); `CHK("on", on_exp(c, s), rd[0])
      end
      load({8'h80, 1'b0, 3'(c), 4'h0}, 16'h3000);
      for (int s = 1; s < 6; s++) begin
        slot(1'b1, s);
        bus_rd(ADDR_STATUS); `CHK("sleep", slp_exp(c, s), rd[0])
      end
    end
    tally_and_finish();
  end
endmodule : clock_output_crystal_control_tb_top
bind clock_output_crystal_control clock_output_crystal_control_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .key_unlocked(key_unlocked), .cfg_load(cfg_load), .slot_evt(slot_evt),
  .pwr_state(pwr_state), .osc_in(osc_in), .on_request(on_request), .on_grant(on_grant),
  .xtal_osc_run(xtal_osc_run), .rtc_clock_en(rtc_clock_en), .clock_src_xtal(clock_src_xtal),
  .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe));
